// File: pkg/msr_bank_regs.svh
// Offsets, field positions and reset values of the feature and exception record bank
`ifndef MSR_BANK_REGS_SVH
`define MSR_BANK_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MISC_FEATURE_ENABLE_OFS         12'h100
`define PLATFORM_REQUIREMENT_REPORT_OFS 12'h1a1
`define EXCEPTION_BRANCH_SOURCE_OFS     12'h1d7
`define EXCEPTION_BRANCH_TARGET_OFS     12'h1d8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LEAF_LIMIT_BIT                  22
`define TASK_PRIORITY_MESSAGE_BIT       23
`define CACHE_CONTEXT_MODE_BIT          24
`define EXECUTE_DISABLE_BIT             34
`define PLATFORM_REQUIRED_BIT           18
`define LEGACY_ADDR_BITS                32

// ----------------------------------------
// Values
// ----------------------------------------
`define LEAF_LIMIT_MAX                  32'h0000_0003
`define MISC_FEATURE_ENABLE_RST         1'b0
`define RECORD_RST                      64'h0000_0000_0000_0000
`define READ_IDLE                       64'h0000_0000_0000_0000

`endif

// File: pkg/msr_bank_pkg.sv
// Types shared by the feature and exception record bank
package msr_bank_pkg;

  // Retired branch, source and target linear addresses
  typedef struct packed {
    logic        valid;
    logic [63:0] source;
    logic [63:0] target;
  } branch_t;

  // Identification query request
  typedef struct packed {
    logic        valid;
    logic [31:0] leaf;
  } id_query_t;

  // Answer to an identification query
  typedef struct packed {
    logic        done;
    logic        hidden;
    logic [31:0] maxLeaf;
  } id_answer_t;

endpackage

// File: rtl/branch_record.sv
// Last branch tracker with an exception-time snapshot register
`timescale 1ns/1ns
`include "msr_bank_regs.svh"

module branch_record #(
  parameter int W = 64
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         clkEn,
  // Branch and exception events
  input  wire logic         branchValid,
  input  wire logic [W-1:0] branchAddr,
  input  wire logic         capture,
  input  wire logic         longMode,
  // Snapshot
  output logic      [W-1:0] record
);

  logic [W-1:0] lastAddr;

  // ----------------------------------------
  // Most recent branch address
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      lastAddr <= W'(`RECORD_RST);
    else if (clkEn && branchValid)
      lastAddr <= branchAddr;
  end

  // ----------------------------------------
  // Snapshot; a branch in the capture cycle comes after the event
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      record <= W'(`RECORD_RST);
    else if (clkEn && capture)
    begin
      if (longMode)
        record <= lastAddr;
      else
        record <= {{(W - `LEGACY_ADDR_BITS){1'b0}}, lastAddr[`LEGACY_ADDR_BITS-1:0]};
    end
  end

endmodule // branch_record

// File: rtl/id_query_filter.sv
// Identification query leaf limiter
`timescale 1ns/1ns
`include "msr_bank_regs.svh"

module id_query_filter #(
  parameter logic [31:0] MAX_LEAF = 32'h0000_0005
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    clkEn,
  // Query and control
  input  wire msr_bank_pkg::id_query_t query,
  input  wire logic                    leafLimit,
  // Answer
  output msr_bank_pkg::id_answer_t     answer
);

  logic [31:0] limitLeaf;

  assign limitLeaf = (MAX_LEAF < `LEAF_LIMIT_MAX) ? MAX_LEAF : `LEAF_LIMIT_MAX;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      answer <= '0;
    else if (clkEn)
    begin
      answer.done    <= query.valid;
      answer.maxLeaf <= leafLimit ? limitLeaf : MAX_LEAF;
      if (query.valid)
        answer.hidden <= leafLimit ? (query.leaf > `LEAF_LIMIT_MAX) : (query.leaf > MAX_LEAF);
    end
  end

endmodule // id_query_filter

// File: rtl/msr_feature_and_exception_record_bank.sv
// Feature-enable controls, platform report and last exception records
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`include "msr_bank_regs.svh"

// How it works
// - Bit 22 of misc_feature_enable is a read-write leaf-limit control.
// - With leaf limit set, identification leaves above 3 are hidden.
// - Bit 24 set selects shared L1 data cache, clear (reset) selects adaptive.
// - Adaptive mode shares L1 only between threads with identical page-table bases.
// - Cache mode bit acts only where multithreading exists; otherwise writes change nothing.
// - Without the context-identifier flag, mode switching is unsupported; firmware leaves bit 24.
// - Read-only platform report; bit 18 flags platform requirements, rest reserved zero.
// - Each exception or interrupt loads source record with last branch address, bits 31:0.
// - In long addressing mode the source record holds the full 64 bits.
// - Target record loads the target of that same last branch.
module msr_feature_and_exception_record_bank #(
  parameter bit          SMT_SUPPORTED        = 1'b1,
  parameter bit          CONTEXT_ID_SUPPORTED = 1'b1,
  parameter bit          PLATFORM_REQUIRED    = 1'b0,
  parameter logic [31:0] MAX_LEAF             = 32'h0000_0005,
  parameter int          PAGE_BASE_W          = 64
) (
  // Clock, reset, enable
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  input  wire logic                     clkEn,
  // Register port
  input  wire logic [11:0]              regAddr,
  input  wire logic [63:0]              regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [63:0]              regRdData,
  // Core events
  input  wire msr_bank_pkg::branch_t    branch,
  input  wire logic                     excEvent,
  input  wire logic                     longMode,
  input  wire logic [PAGE_BASE_W-1:0]   pageTableBase0,
  input  wire logic [PAGE_BASE_W-1:0]   pageTableBase1,
  // Identification query
  input  wire msr_bank_pkg::id_query_t  idQuery,
  output msr_bank_pkg::id_answer_t      idAnswer,
  // Feature controls
  output logic                          taskPriorityMessageDisable,
  output logic                          executeDisable,
  output logic                          cacheSharedMode,
  output logic                          l1ShareData,
  output logic                          featureResultWordContextId
);

  // ----------------------------------------
  // Internal state
  // ----------------------------------------
  logic        leafLimit;
  logic        modeSwitchable;
  logic        selMisc;
  logic        selPlatform;
  logic        selSource;
  logic        selTarget;
  logic        wrMisc;
  logic [63:0] miscValue;
  logic [63:0] platformValue;
  logic [63:0] sourceRecord;
  logic [63:0] targetRecord;
  logic [63:0] next_regRdData;

  assign modeSwitchable = SMT_SUPPORTED && CONTEXT_ID_SUPPORTED;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb
  begin
    selMisc     = 1'b0;
    selPlatform = 1'b0;
    selSource   = 1'b0;
    selTarget   = 1'b0;
    if (regAddr == `MISC_FEATURE_ENABLE_OFS)
      selMisc = 1'b1;
    else if (regAddr == `PLATFORM_REQUIREMENT_REPORT_OFS)
      selPlatform = 1'b1;
    else if (regAddr == `EXCEPTION_BRANCH_SOURCE_OFS)
      selSource = 1'b1;
    else if (regAddr == `EXCEPTION_BRANCH_TARGET_OFS)
      selTarget = 1'b1;
  end

  // Record registers take no write path at all
  assign wrMisc = clkEn && regWr && selMisc;

  // ----------------------------------------
  // Feature-enable fields
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      leafLimit <= `MISC_FEATURE_ENABLE_RST;
    else if (wrMisc)
      leafLimit <= regWrData[`LEAF_LIMIT_BIT];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      taskPriorityMessageDisable <= `MISC_FEATURE_ENABLE_RST;
    else if (wrMisc)
      taskPriorityMessageDisable <= regWrData[`TASK_PRIORITY_MESSAGE_BIT];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      executeDisable <= `MISC_FEATURE_ENABLE_RST;
    else if (wrMisc)
      executeDisable <= regWrData[`EXECUTE_DISABLE_BIT];
  end

  // Mode bit only moves where switching is supported
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cacheSharedMode <= `MISC_FEATURE_ENABLE_RST;
    else if (wrMisc && modeSwitchable)
      cacheSharedMode <= regWrData[`CACHE_CONTEXT_MODE_BIT];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      featureResultWordContextId <= 1'b0;
    else if (clkEn)
      featureResultWordContextId <= CONTEXT_ID_SUPPORTED;
  end

  // ----------------------------------------
  // L1 data sharing between logical processors
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      l1ShareData <= 1'b0;
    else if (clkEn)
    begin
      if (!SMT_SUPPORTED)
        l1ShareData <= 1'b0;
      else if (cacheSharedMode)
        l1ShareData <= 1'b1;
      else
        l1ShareData <= (pageTableBase0 == pageTableBase1);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb
  begin
    miscValue = '0;
    miscValue[`LEAF_LIMIT_BIT]            = leafLimit;
    miscValue[`TASK_PRIORITY_MESSAGE_BIT] = taskPriorityMessageDisable;
    miscValue[`CACHE_CONTEXT_MODE_BIT]    = cacheSharedMode;
    miscValue[`EXECUTE_DISABLE_BIT]       = executeDisable;
    platformValue = '0;
    platformValue[`PLATFORM_REQUIRED_BIT] = PLATFORM_REQUIRED;
  end

  always_comb
  begin
    next_regRdData = `READ_IDLE;
    if (regRd)
    begin
      if (selMisc)
        next_regRdData = miscValue;
      else if (selPlatform)
        next_regRdData = platformValue;
      else if (selSource)
        next_regRdData = sourceRecord;
      else if (selTarget)
        next_regRdData = targetRecord;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdData <= `READ_IDLE;
    else if (clkEn)
      regRdData <= next_regRdData;
  end

  // ----------------------------------------
  // Last exception records
  // ----------------------------------------
  branch_record #(
    .W (64)
  ) sourceRec (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .clkEn       (clkEn),
    .branchValid (branch.valid),
    .branchAddr  (branch.source),
    .capture     (excEvent),
    .longMode    (longMode),
    .record      (sourceRecord)
  );

  branch_record #(
    .W (64)
  ) targetRec (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .clkEn       (clkEn),
    .branchValid (branch.valid),
    .branchAddr  (branch.target),
    .capture     (excEvent),
    .longMode    (longMode),
    .record      (targetRecord)
  );

  // ----------------------------------------
  // Identification query
  // ----------------------------------------
  id_query_filter #(
    .MAX_LEAF (MAX_LEAF)
  ) queryFilter (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .clkEn     (clkEn),
    .query     (idQuery),
    .leafLimit (leafLimit),
    .answer    (idAnswer)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  leaf_limit_write_a: assert property (
    wrMisc |=> leafLimit == $past(regWrData[`LEAF_LIMIT_BIT]))
    else $error("leaf limit bit did not take written value");

  leaf_hidden_a: assert property (
    clkEn && idQuery.valid && leafLimit && idQuery.leaf > `LEAF_LIMIT_MAX
      |=> idAnswer.done && idAnswer.hidden)
    else $error("leaf above limit was not hidden");

  leaf_limit_max_a: assert property (
    clkEn && leafLimit |=> idAnswer.maxLeaf <= `LEAF_LIMIT_MAX)
    else $error("reported top leaf exceeds limit");

  cache_mode_write_a: assert property (
    wrMisc && modeSwitchable |=> cacheSharedMode == $past(regWrData[`CACHE_CONTEXT_MODE_BIT]))
    else $error("cache mode bit did not follow write");

  adaptive_share_a: assert property (
    clkEn && SMT_SUPPORTED && !cacheSharedMode
      |=> l1ShareData == ($past(pageTableBase0) == $past(pageTableBase1)))
    else $error("adaptive sharing does not match page-table bases");

  mode_locked_a: assert property (
    !modeSwitchable |-> !cacheSharedMode && (SMT_SUPPORTED || !l1ShareData))
    else $error("cache mode changed where switching is unsupported");

  platform_read_a: assert property (
    clkEn && regRd && selPlatform |=> regRdData == (64'h1 << `PLATFORM_REQUIRED_BIT) * PLATFORM_REQUIRED)
    else $error("platform report reads wrong value");

  source_legacy_a: assert property (
    clkEn && excEvent && !longMode |=> sourceRecord[63:32] == 32'h0
      && sourceRecord[31:0] == $past(sourceRec.lastAddr[31:0]))
    else $error("source record wrong outside long mode");

  source_long_a: assert property (
    clkEn && excEvent && longMode |=> sourceRecord == $past(sourceRec.lastAddr))
    else $error("source record not full width in long mode");

  target_capture_a: assert property (
    clkEn && excEvent && longMode |=> targetRecord == $past(targetRec.lastAddr))
    else $error("target record not loaded from last branch");

  record_hold_a: assert property (
    !(clkEn && excEvent) |=> $stable(sourceRecord) && $stable(targetRecord))
    else $error("exception record changed without an event");

  cover_long_capture: cover property (clkEn && excEvent && longMode && branch.valid);
  cover_leaf_hidden: cover property (clkEn && idQuery.valid && leafLimit ##1 idAnswer.hidden);
  cover_shared_mode: cover property (wrMisc && regWrData[`CACHE_CONTEXT_MODE_BIT] ##1 cacheSharedMode);
  cover_record_read: cover property (clkEn && regRd && selSource ##1 regRdData != 64'h0);

endmodule // msr_feature_and_exception_record_bank

// File: tb/test_msr_feature_and_exception_record_bank.sv
// Self-checking bench for the feature and exception record bank
`timescale 1ns/1ns
`include "msr_bank_regs.svh"

module test_msr_feature_and_exception_record_bank;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                       sys_clk;
  logic                       reset_n;
  logic                       clkEn;
  logic [11:0]                regAddr;
  logic [63:0]                regWrData;
  logic                       regWr;
  logic                       regRd;
  logic [63:0]                regRdData;
  msr_bank_pkg::branch_t      branch;
  logic                       excEvent;
  logic                       longMode;
  logic [63:0]                pageTableBase0;
  logic [63:0]                pageTableBase1;
  msr_bank_pkg::id_query_t    idQuery;
  msr_bank_pkg::id_answer_t   idAnswer;
  logic                       taskPriorityMessageDisable;
  logic                       executeDisable;
  logic                       cacheSharedMode;
  logic                       l1ShareData;
  logic                       featureResultWordContextId;
  logic [63:0]                regRdDataFix;
  logic                       cacheSharedModeFix;
  logic                       l1ShareDataFix;
  logic                       featureResultWordContextIdFix;
  logic [63:0]                rdFix;
  int                         bad_count;
  int                         cmp_count;
  int                         cycles;
  logic [31:0]                lfsr;
  logic [63:0]                rd;
  logic [63:0]                mask;

  msr_feature_and_exception_record_bank #(
    .SMT_SUPPORTED        (1'b1),
    .CONTEXT_ID_SUPPORTED (1'b1),
    .PLATFORM_REQUIRED    (1'b0),
    .MAX_LEAF             (32'h0000_0005),
    .PAGE_BASE_W          (64)
  ) u_msr_feature_and_exception_record_bank (
    .sys_clk                    (sys_clk),
    .reset_n                    (reset_n),
    .clkEn                      (clkEn),
    .regAddr                    (regAddr),
    .regWrData                  (regWrData),
    .regWr                      (regWr),
    .regRd                      (regRd),
    .regRdData                  (regRdData),
    .branch                     (branch),
    .excEvent                   (excEvent),
    .longMode                   (longMode),
    .pageTableBase0             (pageTableBase0),
    .pageTableBase1             (pageTableBase1),
    .idQuery                    (idQuery),
    .idAnswer                   (idAnswer),
    .taskPriorityMessageDisable (taskPriorityMessageDisable),
    .executeDisable             (executeDisable),
    .cacheSharedMode            (cacheSharedMode),
    .l1ShareData                (l1ShareData),
    .featureResultWordContextId (featureResultWordContextId)
  );

  // No multithreading, no context-id flag, platform bit set
  msr_feature_and_exception_record_bank #(
    .SMT_SUPPORTED        (1'b0),
    .CONTEXT_ID_SUPPORTED (1'b0),
    .PLATFORM_REQUIRED    (1'b1),
    .MAX_LEAF             (32'h0000_0005),
    .PAGE_BASE_W          (64)
  ) u_msr_feature_and_exception_record_bank_nosmt (
    .sys_clk                    (sys_clk),
    .reset_n                    (reset_n),
    .clkEn                      (clkEn),
    .regAddr                    (regAddr),
    .regWrData                  (regWrData),
    .regWr                      (regWr),
    .regRd                      (regRd),
    .regRdData                  (regRdDataFix),
    .branch                     (branch),
    .excEvent                   (excEvent),
    .longMode                   (longMode),
    .pageTableBase0             (pageTableBase0),
    .pageTableBase1             (pageTableBase1),
    .idQuery                    (idQuery),
    .idAnswer                   (),
    .taskPriorityMessageDisable (),
    .executeDisable             (),
    .cacheSharedMode            (cacheSharedModeFix),
    .l1ShareData                (l1ShareDataFix),
    .featureResultWordContextId (featureResultWordContextIdFix)
  );

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  always #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      summarize();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [63:0] rnd64();
    logic [63:0] v;
    for (int i = 0; i < 64; i++)
    begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      v[i] = lfsr[0];
    end
    return v;
  endfunction

  function automatic logic [63:0] recExp(input logic [63:0] a, input logic lm);
    return lm ? a : {32'h0000_0000, a[31:0]};
  endfunction

  task automatic chk(input string name, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic regWrite(input logic [11:0] a, input logic [63:0] d);
    @(posedge sys_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [11:0] a, output logic [63:0] d);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
    rdFix = regRdDataFix;
  endtask

  task automatic query(input logic [31:0] leaf, input logic lim);
    @(posedge sys_clk);
    idQuery <= '{1'b1, leaf};
    @(posedge sys_clk);
    idQuery.valid <= 1'b0;
    #1;
    chk("done", 64'(idAnswer.done), 64'h1);
    chk("hidden", 64'(idAnswer.hidden), 64'(lim ? leaf > 3 : leaf > 5));
    chk("maxLeaf", 64'(idAnswer.maxLeaf), lim ? 64'h3 : 64'h5);
  endtask

  task automatic excTest(input logic lm);
    logic [63:0] a;
    logic [63:0] t;
    a = rnd64();
    t = rnd64();
    @(posedge sys_clk);
    branch   <= '{1'b1, a, t};
    longMode <= lm;
    @(posedge sys_clk);
    branch   <= '{1'b1, rnd64(), rnd64()};
    excEvent <= 1'b1;
    @(posedge sys_clk);
    branch.valid <= 1'b0;
    excEvent     <= 1'b0;
    regRead(`EXCEPTION_BRANCH_SOURCE_OFS, rd);
    chk("source", rd, recExp(a, lm));
    regRead(`EXCEPTION_BRANCH_TARGET_OFS, rd);
    chk("target", rd, recExp(t, lm));
    @(posedge sys_clk);
    branch <= '{1'b1, rnd64(), rnd64()};
    @(posedge sys_clk);
    branch.valid <= 1'b0;
    regWrite(`EXCEPTION_BRANCH_SOURCE_OFS, rnd64());
    regWrite(`EXCEPTION_BRANCH_TARGET_OFS, rnd64());
    regRead(`EXCEPTION_BRANCH_SOURCE_OFS, rd);
    chk("source hold", rd, recExp(a, lm));
    regRead(`EXCEPTION_BRANCH_TARGET_OFS, rd);
    chk("target hold", rd, recExp(t, lm));
  endtask

  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [63:0] d;
    sys_clk = 1'b0;
    reset_n = 1'b0;
    clkEn = 1'b1;
    regAddr = 12'h000;
    regWrData = 64'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    branch = '0;
    excEvent = 1'b0;
    longMode = 1'b0;
    pageTableBase0 = 64'h0;
    pageTableBase1 = 64'h0;
    idQuery = '0;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    lfsr = 32'h958b;
    mask = (64'h1 << `LEAF_LIMIT_BIT) | (64'h1 << `TASK_PRIORITY_MESSAGE_BIT)
         | (64'h1 << `CACHE_CONTEXT_MODE_BIT) | (64'h1 << `EXECUTE_DISABLE_BIT);
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk("cacheShared reset", 64'(cacheSharedMode), 64'h0);
    regRead(`MISC_FEATURE_ENABLE_OFS, rd);
    chk("misc reset", rd, 64'h0);
    chk("contextId", 64'(featureResultWordContextId), 64'h1);
    chk("contextId fixed", 64'(featureResultWordContextIdFix), 64'h0);
    regRead(`PLATFORM_REQUIREMENT_REPORT_OFS, rd);
    chk("platform", rd, 64'h0);
    chk("platform fixed", rdFix, 64'h1 << `PLATFORM_REQUIRED_BIT);
    regWrite(`PLATFORM_REQUIREMENT_REPORT_OFS, 64'hffff_ffff_ffff_ffff);
    regRead(`PLATFORM_REQUIREMENT_REPORT_OFS, rd);
    chk("platform ro", rd, 64'h0);
    chk("platform ro fixed", rdFix, 64'h1 << `PLATFORM_REQUIRED_BIT);
    regWrite(12'h3ff, 64'hffff_ffff_ffff_ffff);
    regRead(12'h3ff, rd);
    chk("unmapped", rd, 64'h0);
    // Random feature-enable writes, corners first
    for (int i = 0; i < 24; i++)
    begin
      d = (i == 0) ? 64'hffff_ffff_ffff_ffff : (i == 1) ? 64'h0 : rnd64();
      regWrite(`MISC_FEATURE_ENABLE_OFS, d);
      regRead(`MISC_FEATURE_ENABLE_OFS, rd);
      chk("misc", rd, d & mask);
      chk("cacheShared", 64'(cacheSharedMode), 64'(d[`CACHE_CONTEXT_MODE_BIT]));
      chk("taskPrio", 64'(taskPriorityMessageDisable), 64'(d[`TASK_PRIORITY_MESSAGE_BIT]));
      chk("execDis", 64'(executeDisable), 64'(d[`EXECUTE_DISABLE_BIT]));
      chk("misc fixed", rdFix, d & mask & ~(64'h1 << `CACHE_CONTEXT_MODE_BIT));
      chk("cacheShared fixed", 64'(cacheSharedModeFix), 64'h0);
    end
    // Leaf limit on identification queries
    for (int lim = 0; lim < 2; lim++)
    begin
      regWrite(`MISC_FEATURE_ENABLE_OFS, 64'(lim) << `LEAF_LIMIT_BIT);
      @(posedge sys_clk);
      for (int leaf = 0; leaf < 8; leaf++)
        query(32'(leaf), lim[0]);
      query(32'hffff_ffff, lim[0]);
    end
    // Adaptive cache sharing follows page-table bases
    regWrite(`MISC_FEATURE_ENABLE_OFS, 64'h0);
    for (int i = 0; i < 6; i++)
    begin
      d = rnd64();
      @(posedge sys_clk);
      pageTableBase0 <= d;
      pageTableBase1 <= i[0] ? d ^ (64'h1 << i) : d;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("l1Share", 64'(l1ShareData), 64'(!i[0]));
      chk("l1Share fixed", 64'(l1ShareDataFix), 64'h0);
    end
    // Shared mode with differing page-table bases
    regWrite(`MISC_FEATURE_ENABLE_OFS, 64'h1 << `CACHE_CONTEXT_MODE_BIT);
    @(posedge sys_clk);
    #1;
    chk("l1Share shared", 64'(l1ShareData), 64'h1);
    chk("l1Share shared fixed", 64'(l1ShareDataFix), 64'h0);
    // Clock enable low freezes the feature fields
    @(posedge sys_clk);
    clkEn <= 1'b0;
    regWrite(`MISC_FEATURE_ENABLE_OFS, 64'h0);
    clkEn <= 1'b1;
    regRead(`MISC_FEATURE_ENABLE_OFS, rd);
    chk("misc frozen", rd, 64'h1 << `CACHE_CONTEXT_MODE_BIT);
    // Exception records in both addressing modes
    for (int i = 0; i < 6; i++)
      excTest(i[0]);
    summarize();
  end

endmodule // test_msr_feature_and_exception_record_bank
